/* src/rfx_irq_ctrl.v */
// Command, state and interrupt aggregation for two radios and two basebands.
// Assumes an SPI front end that turns host accesses into one-cycle strobes on clk.
//
// What this block does
// - Report state code in three read-only bits
// - Command write starts the matching state transition
// - Decode nop, sleep, off, prepare, transmit, receive
// - Reset command settles in transceiver off
// - Merge all four sources onto one pin
// - Separate enable mask per radio and baseband
// - After reset only wake-up stays enabled
// - Four status registers, one per unit
// - Deep wake flags both radios; sleep one
// - Chip reset flags both; transceiver reset one
// - Low battery flags both radios together
// - Sync failure flag only in raw mode
// - Raw mode stops new baseband flags; reads still clear
// - Reading a status register clears it
// - Single reads and block reads both clear
// - Pin active while any enabled flag pends
// - Show-masked bit records disabled events too
// - Baseband mask bit one passes, zero blocks
// - Baseband enable bits seven down to three
// - One queued command, fetched after transition
// - Show-masked clear drops disabled events
// - Wake-up enable forced on in sleep/reset
// - Baseband enable bits two down to zero
`timescale 1ns/1ps
`default_nettype none
`include "rfx_map.vh"

module rfx_irq_ctrl #(
  parameter TRANS_CYCLES = `RFX_TRANS_CYCLES
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [1:0] energy_measure_done,
  input  wire [1:0] pll_lock_error_flag,
  input  wire       low_battery_flag,
  input  wire [1:0] sample_link_sync_fail,
  input  wire [7:0] bb0_events,
  input  wire [7:0] bb1_events,
  input  wire       iq_radio_mode,
  output reg        irq
);

  // Host-visible registers and the power-on wake pulse
  reg [7:0] radio0_irq_flags_q;
  reg [7:0] radio1_irq_flags_q;
  reg [7:0] radio0_irq_enable_q;
  reg [7:0] radio1_irq_enable_q;
  reg [7:0] baseband0_irq_flags_q;
  reg [7:0] baseband1_irq_flags_q;
  reg [7:0] baseband0_irq_enable_q;
  reg [7:0] baseband1_irq_enable_q;
  reg [7:0] irq_config_q;
  reg [2:0] cmd0_q;
  reg [2:0] cmd1_q;
  reg       por_q;

  // Transceiver machine outputs
  wire [2:0] state0;
  wire [2:0] state1;
  wire       asleep0;
  wire       asleep1;
  wire       prep0;
  wire       prep1;
  wire       wake0;
  wire       wake1;
  wire       clr0;
  wire       clr1;

  // Flag update: set wins over the read clear
  function [7:0] flag_next;
    input [7:0] cur;
    input       rd_clr;
    input [7:0] evt;
    input [7:0] mask;
    input       show_masked;
    begin
      flag_next = (rd_clr ? 8'h00 : cur) | (evt & (show_masked ? 8'hff : mask));
    end
  endfunction

  // Radio mask write; wake enable cannot be dropped while held in reset or sleep
  function [7:0] radio_mask_wr;
    input [7:0] wdata;
    input       held;
    begin
      radio_mask_wr = {2'b00, wdata[5:1], wdata[0] | held};
    end
  endfunction

  // Hold wipes a stale release flag, release wipes a stale hold flag
  function [7:0] gain_kill;
    input [7:0] evt;
    begin
      gain_kill = {1'b0, evt[`RFX_BB_GAIN_HOLD], evt[`RFX_BB_GAIN_RELEASE], 5'h00};
    end
  endfunction

  // Frame end or transmit end, only counted in baseband mode
  function frame_done;
    input [7:0] evt;
    input       raw;
    begin
      frame_done = !raw && (evt[`RFX_BB_TX_END] || evt[`RFX_BB_FRAME_END]);
    end
  endfunction

  // Any flag that is both pending and enabled
  function pending;
    input [7:0] flags;
    input [7:0] mask;
    begin
      pending = |(flags & mask);
    end
  endfunction

  // Register strobes
  wire wr_cmd0   = reg_wr && (reg_addr == `RFX_A_RADIO0_CMD);
  wire wr_cmd1   = reg_wr && (reg_addr == `RFX_A_RADIO1_CMD);
  wire rd_rflag0 = reg_rd && (reg_addr == `RFX_A_RADIO0_IRQS);
  wire rd_rflag1 = reg_rd && (reg_addr == `RFX_A_RADIO1_IRQS);
  wire rd_bflag0 = reg_rd && (reg_addr == `RFX_A_BB0_IRQS);
  wire rd_bflag1 = reg_rd && (reg_addr == `RFX_A_BB1_IRQS);
  wire show_m    = irq_config_q[`RFX_CFG_SHOW_MASKED];

  // Deep sleep when both are asleep; an off command wakes both
  wire deep_sleep = asleep0 && asleep1;
  wire off_wr0    = wr_cmd0 && (reg_wdata[2:0] == `RFX_CMD_TRANSCEIVER_OFF);
  wire off_wr1    = wr_cmd1 && (reg_wdata[2:0] == `RFX_CMD_TRANSCEIVER_OFF);
  wire cmd_go0    = wr_cmd0 || (deep_sleep && off_wr1);
  wire cmd_go1    = wr_cmd1 || (deep_sleep && off_wr0);
  wire [2:0] code0 = wr_cmd0 ? reg_wdata[2:0] : `RFX_CMD_TRANSCEIVER_OFF;
  wire [2:0] code1 = wr_cmd1 ? reg_wdata[2:0] : `RFX_CMD_TRANSCEIVER_OFF;

  // Frame end events drop the radio back to prepare in baseband mode
  wire auto0 = frame_done(bb0_events, iq_radio_mode);
  wire auto1 = frame_done(bb1_events, iq_radio_mode);

  // Two transceiver machines
  rfx_trx_fsm #(
    .TRANS_CYCLES (TRANS_CYCLES)
  ) u_trx0 (
    .clk        (clk),
    .rstn       (rstn),
    .cmd_wr     (cmd_go0),
    .cmd_code   (code0),
    .auto_prep  (auto0),
    .state      (state0),
    .asleep     (asleep0),
    .prep_ready (prep0),
    .wake_done  (wake0),
    .regs_clear (clr0)
  );

  rfx_trx_fsm #(
    .TRANS_CYCLES (TRANS_CYCLES)
  ) u_trx1 (
    .clk        (clk),
    .rstn       (rstn),
    .cmd_wr     (cmd_go1),
    .cmd_code   (code1),
    .auto_prep  (auto1),
    .state      (state1),
    .asleep     (asleep1),
    .prep_ready (prep1),
    .wake_done  (wake1),
    .regs_clear (clr1)
  );

  // Radio event vectors
  wire [7:0] radio_evt0;
  wire [7:0] radio_evt1;
  assign radio_evt0 = {2'b00,
                       sample_link_sync_fail[0] & iq_radio_mode,
                       pll_lock_error_flag[0],
                       low_battery_flag,
                       energy_measure_done[0],
                       prep0,
                       wake0 | por_q};
  assign radio_evt1 = {2'b00,
                       sample_link_sync_fail[1] & iq_radio_mode,
                       pll_lock_error_flag[1],
                       low_battery_flag,
                       energy_measure_done[1],
                       prep1,
                       wake1 | por_q};

  // Baseband events; hold and release cancel each other
  wire [7:0] bb_evt0 = iq_radio_mode ? 8'h00 : bb0_events;
  wire [7:0] bb_evt1 = iq_radio_mode ? 8'h00 : bb1_events;
  wire [7:0] bb_kill0 = gain_kill(bb_evt0);
  wire [7:0] bb_kill1 = gain_kill(bb_evt1);

  // Power-on wake pulse, one cycle after reset release
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      por_q <= 1'b1;
    else
      por_q <= 1'b0;
  end

  // Status registers, cleared on read
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      radio0_irq_flags_q    <= 8'h00;
      radio1_irq_flags_q    <= 8'h00;
      baseband0_irq_flags_q <= 8'h00;
      baseband1_irq_flags_q <= 8'h00;
    end
    else
    begin
      radio0_irq_flags_q <= flag_next(radio0_irq_flags_q, rd_rflag0, radio_evt0,
                                      radio0_irq_enable_q, show_m);
      radio1_irq_flags_q <= flag_next(radio1_irq_flags_q, rd_rflag1, radio_evt1,
                                      radio1_irq_enable_q, show_m);
      baseband0_irq_flags_q <= flag_next(baseband0_irq_flags_q & ~bb_kill0, rd_bflag0, bb_evt0,
                                         baseband0_irq_enable_q, show_m);
      baseband1_irq_flags_q <= flag_next(baseband1_irq_flags_q & ~bb_kill1, rd_bflag1, bb_evt1,
                                         baseband1_irq_enable_q, show_m);
    end
  end

  // Radio 0 enable mask
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      radio0_irq_enable_q <= `RFX_RADIO_MASK_RST;
    else if (clr0)
      radio0_irq_enable_q <= `RFX_RADIO_MASK_RST;
    else if (reg_wr && reg_addr == `RFX_A_RADIO0_IRQM)
      radio0_irq_enable_q <= radio_mask_wr(reg_wdata, state0 == `RFX_ST_RESET);
    else if (state0 == `RFX_ST_RESET)
      radio0_irq_enable_q[`RFX_RB_WAKEUP] <= 1'b1;
  end

  // Radio 1 enable mask
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      radio1_irq_enable_q <= `RFX_RADIO_MASK_RST;
    else if (clr1)
      radio1_irq_enable_q <= `RFX_RADIO_MASK_RST;
    else if (reg_wr && reg_addr == `RFX_A_RADIO1_IRQM)
      radio1_irq_enable_q <= radio_mask_wr(reg_wdata, state1 == `RFX_ST_RESET);
    else if (state1 == `RFX_ST_RESET)
      radio1_irq_enable_q[`RFX_RB_WAKEUP] <= 1'b1;
  end

  // Baseband enable masks, all eight bits used
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      baseband0_irq_enable_q <= `RFX_BB_MASK_RST;
      baseband1_irq_enable_q <= `RFX_BB_MASK_RST;
    end
    else
    begin
      if (clr0)
        baseband0_irq_enable_q <= `RFX_BB_MASK_RST;
      else if (reg_wr && reg_addr == `RFX_A_BB0_IRQM)
        baseband0_irq_enable_q <= reg_wdata;
      if (clr1)
        baseband1_irq_enable_q <= `RFX_BB_MASK_RST;
      else if (reg_wr && reg_addr == `RFX_A_BB1_IRQM)
        baseband1_irq_enable_q <= reg_wdata;
    end
  end

  // Config and command readback
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_config_q <= `RFX_CFG_RST;
      cmd0_q       <= `RFX_CMD_NOP;
      cmd1_q       <= `RFX_CMD_NOP;
    end
    else
    begin
      if (reg_wr && reg_addr == `RFX_A_IRQ_CFG)
        irq_config_q <= {4'h0, reg_wdata[`RFX_CFG_SHOW_MASKED], 3'h0};
      if (wr_cmd0)
        cmd0_q <= reg_wdata[2:0];
      if (wr_cmd1)
        cmd1_q <= reg_wdata[2:0];
    end
  end

  // Interrupt pin: any enabled pending flag
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= pending(radio0_irq_flags_q, radio0_irq_enable_q)
           | pending(radio1_irq_flags_q, radio1_irq_enable_q)
           | pending(baseband0_irq_flags_q, baseband0_irq_enable_q)
           | pending(baseband1_irq_flags_q, baseband1_irq_enable_q);
  end

  // Read data, captured from pre-clear values
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `RFX_A_RADIO0_IRQS)
        reg_rdata <= radio0_irq_flags_q;
      else if (reg_addr == `RFX_A_RADIO0_IRQM)
        reg_rdata <= radio0_irq_enable_q;
      else if (reg_addr == `RFX_A_RADIO0_STATE)
        reg_rdata <= {5'h00, state0};
      else if (reg_addr == `RFX_A_RADIO0_CMD)
        reg_rdata <= {5'h00, cmd0_q};
      else if (reg_addr == `RFX_A_RADIO1_IRQS)
        reg_rdata <= radio1_irq_flags_q;
      else if (reg_addr == `RFX_A_RADIO1_IRQM)
        reg_rdata <= radio1_irq_enable_q;
      else if (reg_addr == `RFX_A_RADIO1_STATE)
        reg_rdata <= {5'h00, state1};
      else if (reg_addr == `RFX_A_RADIO1_CMD)
        reg_rdata <= {5'h00, cmd1_q};
      else if (reg_addr == `RFX_A_BB0_IRQS)
        reg_rdata <= baseband0_irq_flags_q;
      else if (reg_addr == `RFX_A_BB0_IRQM)
        reg_rdata <= baseband0_irq_enable_q;
      else if (reg_addr == `RFX_A_BB1_IRQS)
        reg_rdata <= baseband1_irq_flags_q;
      else if (reg_addr == `RFX_A_BB1_IRQM)
        reg_rdata <= baseband1_irq_enable_q;
      else if (reg_addr == `RFX_A_IRQ_CFG)
        reg_rdata <= irq_config_q;
      else
        reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

/* src/rfx_map.vh */
// Register map, field positions, codes and timing for the radio command and irq logic.
// Assumes inclusion by bare name from the design files of this block only.
`ifndef RFX_MAP_VH
`define RFX_MAP_VH

// Register addresses on the internal register port
`define RFX_A_RADIO0_IRQS    8'h00
`define RFX_A_RADIO0_IRQM    8'h01
`define RFX_A_RADIO0_STATE   8'h02
`define RFX_A_RADIO0_CMD     8'h03
`define RFX_A_RADIO1_IRQS    8'h10
`define RFX_A_RADIO1_IRQM    8'h11
`define RFX_A_RADIO1_STATE   8'h12
`define RFX_A_RADIO1_CMD     8'h13
`define RFX_A_BB0_IRQS       8'h20
`define RFX_A_BB0_IRQM       8'h21
`define RFX_A_BB1_IRQS       8'h30
`define RFX_A_BB1_IRQM       8'h31
`define RFX_A_IRQ_CFG        8'h40

// State codes
`define RFX_ST_TRANSCEIVER_OFF        3'h2
`define RFX_ST_TRANSMIT_PREPARE        3'h3
`define RFX_ST_TX            3'h4
`define RFX_ST_RX            3'h5
`define RFX_ST_BUSY          3'h6
`define RFX_ST_RESET         3'h7

// Command codes
`define RFX_CMD_NOP          3'h0
`define RFX_CMD_SLEEP        3'h1
`define RFX_CMD_TRANSCEIVER_OFF       3'h2
`define RFX_CMD_TRANSMIT_PREPARE       3'h3
`define RFX_CMD_TX           3'h4
`define RFX_CMD_RX           3'h5
`define RFX_CMD_RESET        3'h7

// Radio flag bit positions
`define RFX_RB_WAKEUP        0
`define RFX_RB_PREP_READY    1
`define RFX_RB_ENERGY_DONE   2
`define RFX_RB_LOW_BATTERY   3
`define RFX_RB_PLL_ERROR     4
`define RFX_RB_SYNC_FAIL     5

// Baseband flag bit positions
`define RFX_BB_FRAME_START   0
`define RFX_BB_FRAME_END     1
`define RFX_BB_ADDR_MATCH    2
`define RFX_BB_EXT_MATCH     3
`define RFX_BB_TX_END        4
`define RFX_BB_GAIN_HOLD     5
`define RFX_BB_GAIN_RELEASE  6
`define RFX_BB_BUF_LEVEL     7

// Config bit and reset values
`define RFX_CFG_SHOW_MASKED  3
`define RFX_RADIO_MASK_RST   8'h01
`define RFX_BB_MASK_RST      8'h00
`define RFX_CFG_RST          8'h00

// Duration of one state transition
`define RFX_TRANS_NS         1000
`define RFX_CLK_MHZ          20
`define RFX_TRANS_CYCLES     ((`RFX_TRANS_NS * `RFX_CLK_MHZ) / 1000)

`endif

/* src/rfx_trx_fsm.v */
// One transceiver state machine with a one-deep command queue.
// Assumes commands and event pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "rfx_map.vh"

module rfx_trx_fsm #(
  parameter TRANS_CYCLES = `RFX_TRANS_CYCLES
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       cmd_wr,
  input  wire [2:0] cmd_code,
  input  wire       auto_prep,
  output wire [2:0] state,
  output wire       asleep,
  output reg        prep_ready,
  output reg        wake_done,
  output reg        regs_clear
);

  reg [2:0]  cur_q;
  reg        busy_q;
  reg        rst_q;
  reg [2:0]  dest_q;
  reg [15:0] cnt_q;
  reg        pend_v_q;
  reg [2:0]  pend_q;
  reg        rdy_arm_q;
  reg        wake_arm_q;

  // Whether a command may start from the present state
  function legal;
    input [2:0] cur;
    input [2:0] c;
    begin
      case (c)
        `RFX_CMD_SLEEP:  legal = (cur == `RFX_ST_TRANSCEIVER_OFF);
        `RFX_CMD_TRANSCEIVER_OFF: legal = 1'b1;
        `RFX_CMD_TRANSMIT_PREPARE: legal = (cur != `RFX_ST_RESET);
        `RFX_CMD_TX:     legal = (cur == `RFX_ST_TRANSMIT_PREPARE);
        `RFX_CMD_RX:     legal = (cur == `RFX_ST_TRANSMIT_PREPARE) || (cur == `RFX_ST_TRANSCEIVER_OFF);
        default:         legal = 1'b0;
      endcase
    end
  endfunction

  // Command acceptance; nop and code 6 are ignored
  wire       cmd_ok    = cmd_wr && (cmd_code >= `RFX_CMD_SLEEP) && (cmd_code <= `RFX_CMD_RX);
  wire       take_pend = !busy_q && pend_v_q;
  wire [2:0] go_code   = take_pend ? pend_q : cmd_code;
  wire       go        = !busy_q && (take_pend || cmd_ok) && legal(cur_q, go_code);

  // Reported state
  assign state  = (busy_q && !rst_q) ? `RFX_ST_BUSY : cur_q;
  assign asleep = !busy_q && !rst_q && (cur_q == `RFX_ST_RESET);

  // Transition sequencer
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cur_q      <= `RFX_ST_TRANSCEIVER_OFF;
      busy_q     <= 1'b0;
      rst_q      <= 1'b0;
      dest_q     <= `RFX_ST_TRANSCEIVER_OFF;
      cnt_q      <= 16'h0000;
      pend_v_q   <= 1'b0;
      pend_q     <= 3'h0;
      rdy_arm_q  <= 1'b0;
      wake_arm_q <= 1'b0;
      prep_ready <= 1'b0;
      wake_done  <= 1'b0;
      regs_clear <= 1'b0;
    end
    else
    begin
      prep_ready <= 1'b0;
      wake_done  <= 1'b0;
      regs_clear <= 1'b0;
      if (cmd_wr && cmd_code == `RFX_CMD_RESET)
      begin
        // Reset aborts all, then settles in transceiver off
        cur_q      <= `RFX_ST_RESET;
        busy_q     <= 1'b1;
        rst_q      <= 1'b1;
        dest_q     <= `RFX_ST_TRANSCEIVER_OFF;
        cnt_q      <= TRANS_CYCLES[15:0] - 16'h0001;
        pend_v_q   <= 1'b0;
        rdy_arm_q  <= 1'b0;
        wake_arm_q <= 1'b1;
        regs_clear <= 1'b1;
      end
      else if (busy_q)
      begin
        if (cmd_ok)
        begin
          pend_q   <= cmd_code;
          pend_v_q <= 1'b1;
        end
        if (cnt_q == 16'h0000)
        begin
          busy_q     <= 1'b0;
          rst_q      <= 1'b0;
          cur_q      <= dest_q;
          prep_ready <= rdy_arm_q;
          wake_done  <= wake_arm_q;
          regs_clear <= (dest_q == `RFX_ST_RESET);
        end
        else
          cnt_q <= cnt_q - 16'h0001;
      end
      else if (go)
      begin
        // Start a transition; a newer command waits behind it
        busy_q     <= 1'b1;
        dest_q     <= (go_code == `RFX_CMD_SLEEP) ? `RFX_ST_RESET : go_code;
        cnt_q      <= TRANS_CYCLES[15:0] - 16'h0001;
        rdy_arm_q  <= (go_code == `RFX_CMD_TRANSMIT_PREPARE);
        wake_arm_q <= (cur_q == `RFX_ST_RESET);
        pend_v_q   <= take_pend && cmd_ok;
        pend_q     <= cmd_code;
      end
      else
      begin
        pend_v_q <= take_pend && cmd_ok;
        pend_q   <= cmd_code;
        if (auto_prep && (cur_q == `RFX_ST_TX || cur_q == `RFX_ST_RX))
          cur_q <= `RFX_ST_TRANSMIT_PREPARE;
      end
    end
  end

endmodule
`default_nettype wire

/* tb/rfx_irq_ctrl_monitor.sv */
// Checker for the command, state and irq block, bound to its ports.
// Assumes one clock domain and single-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none
module rfx_irq_ctrl_monitor #(
  parameter int TRANS_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] bb0_events,
  input wire logic       iq_radio_mode,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Register port answers
  property p_unmapped_zero;
    reg_rd && reg_addr[7:4] > 4'h4 |=> reg_rdata == 8'h00;
  endproperty
  property p_state_code;
    reg_rd && (reg_addr == 8'h02 || reg_addr == 8'h12) |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] >= 3'h2;
  endproperty
  property p_bb_mask_back;
    reg_wr && reg_addr == 8'h21 ##1 reg_rd && reg_addr == 8'h21 |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_cfg_back;
    reg_wr && reg_addr == 8'h40 ##1 reg_rd && reg_addr == 8'h40 |=> reg_rdata[3] == $past(reg_wdata[3], 2);
  endproperty
  property p_raw_frozen;
    iq_radio_mode && $past(iq_radio_mode) && $past(iq_radio_mode, 2) && reg_rd && reg_addr == 8'h20
      && $past(reg_rd, 2) && $past(reg_addr, 2) == 8'h20 |=> reg_rdata == 8'h00;
  endproperty
  // Command responses
  property p_cmd_busy;
    reg_wr && reg_addr == 8'h03 && reg_wdata == 8'h02 ##1 reg_rd && reg_addr == 8'h02 |=> reg_rdata == 8'h06;
  endproperty
  property p_cmd_reset;
    reg_wr && reg_addr == 8'h03 && reg_wdata == 8'h07 ##1 reg_rd && reg_addr == 8'h02 |=> reg_rdata == 8'h07;
  endproperty
  // Interrupt pin
  property p_bb_irq;
    reg_wr && reg_addr == 8'h21 && reg_wdata == 8'hff ##2 (bb0_events != 8'h00 && !iq_radio_mode) |-> ##2 irq;
  endproperty
  property p_wake_after_rst;
    $rose(rstn) |-> ##[2:3] irq;
  endproperty

  a_unmapped_zero:  assert property (p_unmapped_zero)  else $error("unmapped read not zero");
  a_state_code:     assert property (p_state_code)     else $error("bad state code");
  a_bb_mask_back:   assert property (p_bb_mask_back)   else $error("baseband mask readback");
  a_cfg_back:       assert property (p_cfg_back)       else $error("config readback");
  a_raw_frozen:     assert property (p_raw_frozen)     else $error("baseband flags moved in raw mode");
  a_cmd_busy:       assert property (p_cmd_busy)       else $error("no busy code after command");
  a_cmd_reset:      assert property (p_cmd_reset)      else $error("no reset code after reset cmd");
  a_bb_irq:         assert property (p_bb_irq)         else $error("enabled event gave no irq");
  a_wake_after_rst: assert property (p_wake_after_rst) else $error("no wake irq after reset");

  // Main scenarios reached
  c_reset_cmd: cover property (reg_wr && reg_addr == 8'h03 && reg_wdata == 8'h07);
  c_bb_irq:    cover property (bb0_events != 8'h00 ##2 irq);
  c_raw_read:  cover property (iq_radio_mode && reg_rd && reg_addr == 8'h20);
endmodule
bind rfx_irq_ctrl rfx_irq_ctrl_monitor #(.TRANS_CYCLES(TRANS_CYCLES)) u_mon (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .bb0_events(bb0_events), .iq_radio_mode(iq_radio_mode), .irq(irq)
);
`default_nettype wire

/* tb/rfx_host_model.sv */
// Host agent for the register port: single writes and block reads.
// Assumes callers sit one step after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rfx_host_model (
  input  wire logic       clk,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  logic [7:0] got [4];

  // Idle port at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // One write strobe; commands ride on it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask

  // Reads n successive addresses back to back
  task automatic rd_blk(input logic [7:0] a, input int n, input logic now);
    if (!now)
    begin
      @(posedge clk);
      #1;
    end
    for (int i = 0; i < n; i++)
    begin
      reg_addr = a + 8'(i);
      reg_rd   = 1'b1;
      @(posedge clk);
      #1;
      got[i] = reg_rdata;
    end
    reg_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/rfx_irq_ctrl_tb.sv */
// Self-checking bench for the command, state and irq block.
// Assumes the host model owns the register port; events come from here.
`timescale 1ns/1ps
`default_nettype none
module rfx_irq_ctrl_tb;
  localparam int TC = 3;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, irq;
  logic       low_battery_flag = 1'b0;
  logic       iq_radio_mode = 1'b0;
  logic [1:0] energy_measure_done = 2'h0, pll_lock_error_flag = 2'h0, sample_link_sync_fail = 2'h0;
  logic [7:0] bb0_events = 8'h00, bb1_events = 8'h00;
  logic [2:0] cmds [6] = '{3'h2, 3'h5, 3'h3, 3'h2, 3'h1, 3'h2};
  logic [2:0] dest [6] = '{3'h2, 3'h5, 3'h3, 3'h2, 3'h7, 3'h2};
  int         num_errors = 0;
  int         num_checks = 0;

  always #25 clk = ~clk;

  rfx_irq_ctrl #(.TRANS_CYCLES(TC)) u_dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .energy_measure_done(energy_measure_done), .pll_lock_error_flag(pll_lock_error_flag),
    .low_battery_flag(low_battery_flag), .sample_link_sync_fail(sample_link_sync_fail), .bb0_events(bb0_events),
    .bb1_events(bb1_events), .iq_radio_mode(iq_radio_mode), .irq(irq)
  );
  rfx_host_model u_host (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic now);
    u_host.rd_blk(a, 1, now);
    chk(u_host.got[0], e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One-cycle event pulse on every source at once
  task automatic ev(input logic lb, input logic [1:0] en, input logic [1:0] pl, input logic [1:0] sy,
                    input logic [7:0] b0, input logic [7:0] b1);
    @(posedge clk);
    #1;
    {low_battery_flag, energy_measure_done, pll_lock_error_flag, sample_link_sync_fail} = {lb, en, pl, sy};
    {bb0_events, bb1_events} = {b0, b1};
    @(posedge clk);
    #1;
    {low_battery_flag, energy_measure_done, pll_lock_error_flag, sample_link_sync_fail} = 7'h00;
    {bb0_events, bb1_events} = 16'h0000;
  endtask
  task automatic complete_run;
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run;
  end

  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    idle(4);
    chk({7'h00, irq}, 8'h01);
    u_host.rd_blk(8'h00, 3, 1'b0);
    chk(u_host.got[0], 8'h01);
    chk(u_host.got[1], 8'h01);
    chk(u_host.got[2], 8'h02);
    rc(8'h00, 8'h00, 1'b0);
    chk({7'h00, irq}, 8'h01);
    rc(8'h10, 8'h01, 1'b0);
    idle(2);
    chk({7'h00, irq}, 8'h00);
    rc(8'h11, 8'h01, 1'b0);
    rc(8'h21, 8'h00, 1'b0);
    rc(8'h31, 8'h00, 1'b0);
    rc(8'h40, 8'h00, 1'b0);
    rc(8'h50, 8'h00, 1'b0);
    // Queued command behind a running one, then ignored codes
    u_host.wr(8'h01, 8'h03);
    u_host.wr(8'h03, 8'h03);
    rc(8'h02, 8'h06, 1'b1);
    u_host.wr(8'h03, 8'h04);
    idle(4 * TC);
    rc(8'h02, 8'h04, 1'b0);
    rc(8'h00, 8'h02, 1'b0);
    u_host.wr(8'h03, 8'h00);
    u_host.wr(8'h03, 8'h06);
    rc(8'h02, 8'h04, 1'b1);
    ev(1'b0, 2'h0, 2'h0, 2'h0, 8'h10, 8'h00);
    rc(8'h02, 8'h03, 1'b0);
    rc(8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      u_host.wr(8'h03, {5'h00, cmds[i]});
      rc(8'h02, 8'h06, 1'b1);
      idle(2 * TC);
      rc(8'h02, {5'h00, dest[i]}, 1'b0);
    end
    rc(8'h00, 8'h03, 1'b0);
    rc(8'h10, 8'h00, 1'b0);
    // Transceiver reset with wake enable cleared beforehand
    u_host.wr(8'h01, 8'h00);
    u_host.wr(8'h03, 8'h07);
    rc(8'h02, 8'h07, 1'b1);
    rc(8'h01, 8'h01, 1'b0);
    idle(2 * TC);
    rc(8'h02, 8'h02, 1'b0);
    rc(8'h00, 8'h01, 1'b0);
    rc(8'h10, 8'h00, 1'b0);
    // Both radios asleep, one wake command
    u_host.wr(8'h03, 8'h01);
    u_host.wr(8'h13, 8'h01);
    idle(2 * TC);
    u_host.wr(8'h11, 8'h00);
    rc(8'h11, 8'h01, 1'b1);
    u_host.wr(8'h03, 8'h02);
    idle(4 * TC);
    rc(8'h00, 8'h01, 1'b0);
    rc(8'h10, 8'h01, 1'b0);
    // Each baseband enable bit alone, bits 0-4 and 7 firing too
    for (int i = 0; i < 8; i++)
    begin
      u_host.wr(8'h21, 8'h01 << i);
      rc(8'h21, 8'h01 << i, 1'b1);
      ev(1'b0, 2'h0, 2'h0, 2'h0, (8'h01 << i) | 8'h9f, 8'h00);
      idle(1);
      chk({7'h00, irq}, 8'h01);
      rc(8'h20, 8'h01 << i, 1'b0);
      idle(2);
      chk({7'h00, irq}, 8'h00);
    end
    u_host.wr(8'h21, 8'hff);
    ev(1'b0, 2'h0, 2'h0, 2'h0, 8'h81, 8'h00);
    idle(1);
    chk({7'h00, irq}, 8'h01);
    rc(8'h20, 8'h81, 1'b0);
    u_host.wr(8'h31, 8'h10);
    ev(1'b0, 2'h0, 2'h0, 2'h0, 8'h00, 8'h10);
    idle(1);
    chk({7'h00, irq}, 8'h01);
    rc(8'h30, 8'h10, 1'b0);
    // Disabled events shown in status, pin quiet
    u_host.wr(8'h40, 8'h08);
    rc(8'h40, 8'h08, 1'b1);
    u_host.wr(8'h21, 8'h00);
    ev(1'b0, 2'h0, 2'h0, 2'h0, 8'h04, 8'h00);
    idle(1);
    chk({7'h00, irq}, 8'h00);
    rc(8'h20, 8'h04, 1'b0);
    ev(1'b1, 2'h0, 2'h0, 2'h0, 8'h00, 8'h00);
    rc(8'h00, 8'h08, 1'b0);
    rc(8'h10, 8'h08, 1'b0);
    ev(1'b0, 2'h1, 2'h2, 2'h0, 8'h00, 8'h00);
    u_host.rd_blk(8'h10, 2, 1'b0);
    chk(u_host.got[0], 8'h10);
    rc(8'h00, 8'h04, 1'b0);
    rc(8'h10, 8'h00, 1'b0);
    // Raw sample mode
    iq_radio_mode = 1'b1;
    ev(1'b0, 2'h0, 2'h0, 2'h3, 8'h01, 8'h00);
    rc(8'h20, 8'h00, 1'b0);
    rc(8'h20, 8'h00, 1'b0);
    rc(8'h00, 8'h20, 1'b0);
    rc(8'h10, 8'h20, 1'b0);
    iq_radio_mode = 1'b0;
    ev(1'b0, 2'h0, 2'h0, 2'h1, 8'h00, 8'h00);
    rc(8'h00, 8'h00, 1'b0);
    complete_run;
  end
endmodule
`default_nettype wire
